// file: logic/done_notify_pkg.sv
// Package for the command completion notifier.
// Assumes a single 100 MHz core clock domain.
package done_notify_pkg;

   // ****************************************
   // Reset values and encodings
   // ****************************************
   localparam logic       STATUS_RESET   = 1'h1;
   localparam logic       POLARITY_DFLT  = 1'h1;
   localparam logic [1:0] OP_PROGRAM     = 2'h0;
   localparam logic [1:0] OP_ERASE       = 2'h1;
   localparam logic [1:0] OP_LOAD        = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BUSY
   } notify_state_e;

   // Status write request from the host side register path
   typedef struct packed {
      logic valid;
      logic value;
   } status_wr_s;

   // Completion report from the internal controller
   typedef struct packed {
      logic       valid;
      logic [1:0] kind;
   } op_done_s;

endpackage

// file: logic/notify_pin_drv.sv
// Open-drain driver stage for the completion pin.
// Assumes an external pull-up; pin level is resolved outside.
`timescale 1ns/10ps

module notify_pin_drv (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic level_want,
   output logic      pin_o,
   output logic      pin_oe
);

   // ****************************************
   // Drive stage
   // ****************************************
   // Pin only pulls low; a high level is left to the pull-up
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_oe <= 1'h0;
         pin_o  <= 1'h0;
      end else begin
         pin_oe <= ~level_want;
         pin_o  <= 1'h0;
      end
   end

endmodule

// file: logic/command_done_notify.sv
// Completion notifier: interrupt status bit and open-drain done pin.
// Assumes host register writes and controller done pulses are synchronous to core_clk.
`timescale 1ns/10ps

// Overview of operation
// - Idle with default polarity, the done pin rests high.
// - Clearing the status bit drives the pin to its in-progress level.
// - Controller finishing returns the pin to its completion level.
// - Program, erase and load completions all report through the pin.
// - Pin is open drain so several devices can be wire-ORed.
// - Pin keeps its level when deselected or outputs disabled.
module command_done_notify (
   input  wire logic                        core_clk,
   input  wire logic                        rstn,
   input  wire done_notify_pkg::status_wr_s status_wr,
   input  wire done_notify_pkg::op_done_s   op_done,
   input  wire logic                        polarity_high,
   input  wire logic                        chip_sel_n,
   input  wire logic                        out_en_n,
   input  wire logic                        addr_valid_strobe_n,
   output logic                             status_bit,
   output logic [1:0]                       last_op_kind,
   output logic                             busy,
   output logic                             notify_pin_o,
   output logic                             notify_pin_oe
);

   // ****************************************
   // Status bit and state
   // ****************************************
   done_notify_pkg::notify_state_e state_reg;
   logic                           level_next;

   // Electrical sense of the pin for a given status and polarity
   function automatic logic pin_level(
      input logic pol,
      input logic status
   );
      return pol ? status : ~status;
   endfunction

   // Completion sets, host write loads the written value; set wins on collision
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_bit <= done_notify_pkg::STATUS_RESET;
      end else if (op_done.valid) begin
         status_bit <= 1'h1;
      end else if (status_wr.valid) begin
         status_bit <= status_wr.value;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= done_notify_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            done_notify_pkg::ST_IDLE: begin
               if (status_wr.valid && !status_wr.value && !op_done.valid) begin
                  state_reg <= done_notify_pkg::ST_BUSY;
               end
            end
            done_notify_pkg::ST_BUSY: begin
               if (op_done.valid) begin
                  state_reg <= done_notify_pkg::ST_IDLE;
               end
            end
            default: state_reg <= done_notify_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy         <= 1'h0;
         last_op_kind <= done_notify_pkg::OP_PROGRAM;
      end else begin
         busy <= (state_reg == done_notify_pkg::ST_BUSY) && !op_done.valid;
         if (op_done.valid) begin
            last_op_kind <= op_done.kind;
         end
      end
   end

   // ****************************************
   // Pin level
   // ****************************************
   // Chip select, output enable and strobe are deliberately not used:
   // the pin never floats with the bus state
   always_comb begin
      // Status high means done; polarity picks the electrical sense
      level_next = pin_level(polarity_high, status_bit);
   end

   notify_pin_drv u_drv (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .level_want (level_next),
      .pin_o      (notify_pin_o),
      .pin_oe     (notify_pin_oe)
   );

   // ****************************************
   // Checks
   // ****************************************
   chk_clear_drives_low: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_wr.valid && !status_wr.value && !op_done.valid && polarity_high)
      |=> ##1 notify_pin_oe)
      else $error("Pin not pulled low after status clear");

   chk_done_releases: assert property (@(posedge core_clk) disable iff (!rstn)
      (op_done.valid && polarity_high) |=> ##1 !notify_pin_oe)
      else $error("Pin not released after completion");

   chk_idle_high: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_bit && polarity_high && $stable(polarity_high)) |=> !notify_pin_oe)
      else $error("Pin driven low while idle");

   chk_open_drain: assert property (@(posedge core_clk) disable iff (!rstn)
      !notify_pin_o)
      else $error("Pin driven high");

   chk_pol_invert: assert property (@(posedge core_clk) disable iff (!rstn)
      (!polarity_high && $stable(polarity_high)) |=> (notify_pin_oe == $past(status_bit)))
      else $error("Inverted polarity level wrong");

   chk_desel_kept: assert property (@(posedge core_clk) disable iff (!rstn)
      (chip_sel_n && out_en_n && !status_bit && polarity_high && $stable(polarity_high))
      |=> notify_pin_oe)
      else $error("Pin released while deselected");

   chk_done_kind: assert property (@(posedge core_clk) disable iff (!rstn)
      op_done.valid |=> (last_op_kind == $past(op_done.kind)) && status_bit)
      else $error("Completion not recorded");

   chk_busy_track: assert property (@(posedge core_clk) disable iff (!rstn)
      busy |-> !status_bit)
      else $error("Busy with status showing done");

   // ****************************************
   // Status bit and operation kind checks
   // ****************************************
   chk_clear_status: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_wr.valid && !status_wr.value && !op_done.valid) |=> !status_bit)
      else $error("Status bit not cleared by host write");

   // A clear that meets a completion must not leave the host waiting forever
   chk_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
      (status_wr.valid && op_done.valid) |=> status_bit)
      else $error("Completion lost against status clear");

   chk_status_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      (!op_done.valid && !status_wr.valid) |=> $stable(status_bit))
      else $error("Status bit moved without a cause");

   chk_kind_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      !op_done.valid |=> $stable(last_op_kind))
      else $error("Operation kind moved without completion");

   // ****************************************
   // Busy flag checks
   // ****************************************
   chk_busy_start: assert property (@(posedge core_clk) disable iff (!rstn)
      ((status_wr.valid && !status_wr.value && !op_done.valid && !busy && status_bit)
      ##1 !op_done.valid) |=> busy)
      else $error("Busy not raised after status clear");

   chk_busy_end: assert property (@(posedge core_clk) disable iff (!rstn)
      op_done.valid |=> !busy)
      else $error("Busy still high after completion");

   // ****************************************
   // Pin level and state encoding checks
   // ****************************************
   chk_oe_follows: assert property (@(posedge core_clk) disable iff (!rstn)
      (polarity_high && $stable(polarity_high)) |=> (notify_pin_oe == !$past(status_bit)))
      else $error("Pin level does not follow status");

   chk_running_low: assert property (@(posedge core_clk) disable iff (!rstn)
      (!status_bit && polarity_high && $stable(polarity_high)) |=> notify_pin_oe)
      else $error("Pin not low while operation runs");

   // Bus select pins must never disturb the pin; it is not a bus output
   chk_sel_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
      ($changed(chip_sel_n) && $stable(status_bit) && $stable(polarity_high))
      |=> $stable(notify_pin_oe))
      else $error("Pin moved with chip select");

   chk_oe_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
      ($changed(out_en_n) && $stable(status_bit) && $stable(polarity_high))
      |=> $stable(notify_pin_oe))
      else $error("Pin moved with output enable");

   chk_strobe_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
      ($changed(addr_valid_strobe_n) && $stable(status_bit) && $stable(polarity_high))
      |=> $stable(notify_pin_oe))
      else $error("Pin moved with address strobe");

   chk_state_legal: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_reg == done_notify_pkg::ST_IDLE) || (state_reg == done_notify_pkg::ST_BUSY))
      else $error("Tracking state left its legal codes");

endmodule

// file: verif/host_model.sv
// Host side of the done pin: pull-up, GPIO edge watch, bus wiring.
// Assumes the bench drives the host chip select.
`timescale 1ns/10ps

module host_model (
   input  wire logic core_clk,
   input  wire logic host_cs_n,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output logic      pin_lvl,
   output logic      dev_cs_n,
   output logic      dev_strobe_n,
   output int        rise_cnt
);
   logic last_reg;
   int   cnt_reg = 0;
   // Released pin floats up through the pull-up
   assign pin_lvl = pin_oe ? pin_o : 1'h1;
   assign dev_cs_n = host_cs_n;
   assign dev_strobe_n = host_cs_n;
   assign rise_cnt = cnt_reg;
   always @(posedge core_clk) begin
      if (pin_lvl === 1'h1 && last_reg === 1'h0) cnt_reg <= cnt_reg + 1;
      last_reg <= pin_lvl;
   end
endmodule

// file: verif/tb.sv
// Testbench for the completion notifier.
// Assumes the design latencies of two edges from request to pin.
`timescale 1ns/10ps

module tb;
   logic                        core_clk, rstn, pol, cs_n, oe_n;
   done_notify_pkg::status_wr_s wr;
   done_notify_pkg::op_done_s   done;
   logic                        st, busy, pin_o, pin_oe, lvl, dcs_n, strobe_n;
   logic [1:0]                  kind;
   int                          rise_cnt, r, bad_count, checks;

   command_done_notify i_dut (.core_clk, .rstn, .status_wr(wr), .op_done(done),
      .polarity_high(pol), .chip_sel_n(dcs_n), .out_en_n(oe_n),
      .addr_valid_strobe_n(strobe_n), .status_bit(st), .last_op_kind(kind),
      .busy, .notify_pin_o(pin_o), .notify_pin_oe(pin_oe));
   host_model i_host (.core_clk, .host_cs_n(cs_n), .pin_o, .pin_oe,
      .pin_lvl(lvl), .dev_cs_n(dcs_n), .dev_strobe_n(strobe_n), .rise_cnt);

   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic cmp1(input logic e, input logic a);
      checks++;
      if (a !== e) begin
         bad_count++;
         $display("[ERR] %0t bit got %b want %b", $time, a, e);
      end
   endtask

   task automatic cmp2(input logic [1:0] e, input logic [1:0] a);
      checks++;
      if (a !== e) begin
         bad_count++;
         $display("[ERR] %0t kind got %h want %h", $time, a, e);
      end
   endtask

   task automatic edges(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Deselected and outputs off while running: pin must still hold its in-progress level
   task automatic run_op(input logic [1:0] k);
      wr = '{1'h1, 1'h0};
      edges(1);
      wr = '0;
      cs_n = 1'h1;
      oe_n = 1'h1;
      edges(2);
      cmp1(~pol, lvl);
      cmp1(1'h1, busy);
      // Counted from here: only the completion edge may rise
      r = rise_cnt;
      done = '{1'h1, k};
      edges(1);
      done = '0;
      cs_n = 1'h0;
      oe_n = 1'h0;
      edges(2);
      cmp1(pol, lvl);
      cmp1(1'h1, st);
      cmp2(k, kind);
      cmp1(pol, rise_cnt == r + 1);
   endtask

   // Polling instead of the pin; then a clear that meets a completion
   task automatic poll_op;
      wr = '{1'h1, 1'h0};
      edges(1);
      wr = '0;
      edges(1);
      cmp1(1'h0, st);
      done = '{1'h1, done_notify_pkg::OP_ERASE};
      edges(1);
      done = '0;
      cmp1(1'h1, st);
      cmp2(done_notify_pkg::OP_ERASE, kind);
      wr = '{1'h1, 1'h0};
      done = '{1'h1, done_notify_pkg::OP_PROGRAM};
      edges(1);
      wr = '0;
      done = '0;
      cmp1(1'h1, st);
      edges(2);
      cmp1(1'h1, lvl);
   endtask

   task automatic results;
      $display("bad_count=%0d checks=%0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      results;
   end

   initial begin
      {rstn, pol, cs_n, oe_n, wr, done} = '0;
      bad_count = 0;
      checks = 0;
      pol = 1'h1;
      edges(5);
      rstn = 1'h1;
      edges(3);
      cmp1(1'h1, lvl);
      cmp1(1'h1, st);
      for (int k = 0; k < 3; k++) run_op(k[1:0]);
      poll_op();
      pol = 1'h0;
      edges(3);
      cmp1(1'h0, lvl);
      run_op(done_notify_pkg::OP_LOAD);
      results;
   end
endmodule
